// >>> src/chg_otc_pkg.sv
// package: register map, field positions, reset values, timing and types
package chg_otc_pkg;

	// ==========================================================
	// register bus
	localparam int           ADDR_W      = 8;
	localparam int           DATA_W      = 16;
	localparam logic [7:0]   ADDR_CONFIG = 8'h00;
	localparam logic [7:0]   ADDR_DBTIME = 8'h01;
	localparam logic [7:0]   ADDR_OTCTHR = 8'h02;
	localparam logic [7:0]   ADDR_OTCREC = 8'h03;
	localparam logic [7:0]   ADDR_OTCDLY = 8'h04;
	localparam logic [7:0]   ADDR_ALMSTA = 8'h05;
	localparam logic [7:0]   ADDR_ALMENA = 8'h06;
	localparam logic [7:0]   ADDR_STATUS = 8'h07;
	localparam logic [7:0]   ADDR_RECCMD = 8'h0A;
	localparam logic [7:0]   ADDR_REGOUT = 8'h69;

	// ==========================================================
	// field positions
	localparam int           CFG_CHGDET_EN   = 0;
	localparam int           CFG_OTC_EN      = 1;
	localparam int           CFG_OTC_FET     = 2;
	localparam int           CFG_OSC_OFF     = 3;
	localparam int           ALM_CHANGE      = 0;
	localparam int           STA_RAW         = 0;
	localparam int           STA_DEBOUNCED   = 1;
	localparam int           STA_OTC_ALERT   = 2;
	localparam int           STA_OTC_FAULT   = 3;
	localparam int           STA_OSC_REQ     = 4;
	localparam int           REC_TEMP        = 0;
	localparam int           REGOUT_BIAS_ON  = 0;

	// ==========================================================
	// reset values
	localparam logic [3:0]   CONFIG_RST = 4'h0;
	localparam logic [7:0]   DBTIME_RST = 8'h01;
	localparam logic [7:0]   OTCTHR_RST = 8'h00;
	localparam logic [7:0]   OTCREC_RST = 8'h00;
	localparam logic [7:0]   OTCDLY_RST = 8'h00;
	localparam logic         ALMENA_RST = 1'b0;
	localparam logic         REGOUT_RST = 1'b0;

	// ==========================================================
	// thresholds: one setting step is this many adc counts
	localparam logic [15:0]  THR_STEP = 16'h0036;

	// ==========================================================
	// debounce timebase: one tick every 100 ms at 250 MHz
	localparam int           TICK_MS      = 100;
	localparam int           CLK_KHZ      = 250000;
	localparam int           TICK_CYCLES  = TICK_MS * CLK_KHZ;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		OTC_NORMAL = 3'b001,
		OTC_ALERT  = 3'b010,
		OTC_TRIP   = 3'b100
	} otc_state_e;

	typedef struct packed {
		logic        valid;
		logic [15:0] result;
	} therm_meas_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_s;

endpackage

// >>> src/chg_otc_protect.sv
// charge-pin detector debounce and charge overtemperature protection
//
// How it works
// RQ1 - detector evaluated only when enable bit set
// RQ2 - raw detector value readable at any time
// RQ3 - debounced copy after stable beyond interval
// RQ4 - debounce interval counts 100 ms ticks
// RQ5 - change of debounced value sets alarm flag
// RQ6 - alert output gated by alarm enable mask
// RQ7 - writing one clears alarm flag
// RQ8 - mismatch wakes oscillator to time debounce
// RQ9 - deep sleep: oscillator off after new value
// RQ10 - alert when thermistor result below threshold
// RQ11 - thresholds are 54-count steps up to 13770
// RQ12 - overtemp detection only when enabled
// RQ13 - fault after configured consecutive alert measurements
// RQ14 - in sleep evaluate only during bursts
// RQ15 - alert holds normal mode until resolved
// RQ16 - trip clears alert, sets fault status
// RQ17 - fault turns charge fet off if configured
// RQ18 - recovery at or above recovery threshold
// RQ19 - zero recovery threshold needs host command
// RQ20 - thermistor bias during measurement or when forced
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module chg_otc_protect #(
	parameter int TICK_COUNT = chg_otc_pkg::TICK_CYCLES
) (
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	input  wire chg_otc_pkg::reg_req_s    regReq,
	output logic [chg_otc_pkg::DATA_W-1:0] regRdata_q,
	input  wire logic                     chgDetectPin,
	input  wire logic                     lowestPowerState,
	input  wire logic                     sleepMode,
	input  wire logic                     sleepBurst,
	input  wire logic                     thermMeasuring,
	input  wire chg_otc_pkg::therm_meas_s thermMeas,
	output logic                          alert_q,
	output logic                          chargeFetOff_q,
	output logic                          oscRequest_q,
	output logic                          normalModeReq_q,
	output logic                          thermBias_q
);
	import chg_otc_pkg::*;

	// ==========================================================
	// register state
	logic [3:0]  config_q;
	logic [7:0]  dbTime_q;
	logic [7:0]  otcThr_q;
	logic [7:0]  otcRec_q;
	logic [7:0]  otcDly_q;
	logic        almEnable_q;
	logic        changeAlarm_q;
	logic        biasOn_q;
	logic        tempRecReq;
	logic        wrEn;
	logic        rdEn;

	assign wrEn = regReq.wr;
	assign rdEn = regReq.rd;

	// per-register write strobes
	logic wrConfig;
	logic wrDbTime;
	logic wrOtcThr;
	logic wrOtcRec;
	logic wrOtcDly;
	logic wrAlmSta;
	logic wrAlmEna;
	logic wrRecCmd;
	logic wrRegOut;

	// status and unmapped offsets decode to no strobe at all
	assign wrConfig = wrEn && regReq.addr == ADDR_CONFIG;
	assign wrDbTime = wrEn && regReq.addr == ADDR_DBTIME;
	assign wrOtcThr = wrEn && regReq.addr == ADDR_OTCTHR;
	assign wrOtcRec = wrEn && regReq.addr == ADDR_OTCREC;
	assign wrOtcDly = wrEn && regReq.addr == ADDR_OTCDLY;
	assign wrAlmSta = wrEn && regReq.addr == ADDR_ALMSTA;
	assign wrAlmEna = wrEn && regReq.addr == ADDR_ALMENA;
	assign wrRecCmd = wrEn && regReq.addr == ADDR_RECCMD;
	assign wrRegOut = wrEn && regReq.addr == ADDR_REGOUT;

	// host recovery command is a write pulse, never stored
	assign tempRecReq = wrRecCmd && regReq.wdata[REC_TEMP]; // RQ19

	// enable, fet control and deep-sleep oscillator bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			config_q <= CONFIG_RST;
		end else if (wrConfig) begin
			config_q <= regReq.wdata[3:0];
		end
	end

	// debounce interval in 100 ms ticks
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dbTime_q <= DBTIME_RST;
		end else if (wrDbTime) begin
			dbTime_q <= regReq.wdata[7:0]; // RQ4
		end
	end

	// overtemperature threshold step
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			otcThr_q <= OTCTHR_RST;
		end else if (wrOtcThr) begin
			otcThr_q <= regReq.wdata[7:0]; // RQ11
		end
	end

	// recovery threshold step; zero means host recovery only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			otcRec_q <= OTCREC_RST;
		end else if (wrOtcRec) begin
			otcRec_q <= regReq.wdata[7:0]; // RQ11
		end
	end

	// consecutive measurements before a trip
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			otcDly_q <= OTCDLY_RST;
		end else if (wrOtcDly) begin
			otcDly_q <= regReq.wdata[7:0]; // RQ13
		end
	end

	// alarm mask for the alert output
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			almEnable_q <= ALMENA_RST;
		end else if (wrAlmEna) begin
			almEnable_q <= regReq.wdata[ALM_CHANGE]; // RQ6
		end
	end

	// forced thermistor bias from the regulator control command
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			biasOn_q <= REGOUT_RST;
		end else if (wrRegOut) begin
			biasOn_q <= regReq.wdata[REGOUT_BIAS_ON]; // RQ20
		end
	end

	logic charge_detect_enable;
	logic otcEn;
	logic otcFetCtrl;
	logic oscOffSleep;

	assign charge_detect_enable    = config_q[CFG_CHGDET_EN];
	assign otcEn       = config_q[CFG_OTC_EN];
	assign otcFetCtrl  = config_q[CFG_OTC_FET];
	assign oscOffSleep = config_q[CFG_OSC_OFF];

	// ==========================================================
	// charge-pin detector: synchroniser
	logic syncA_q;
	logic rawDet_q;

	// two flops before anything reads the pin
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			syncA_q  <= 1'b0;
			rawDet_q <= 1'b0;
		end else begin
			syncA_q  <= chgDetectPin;
			rawDet_q <= syncA_q;
		end
	end

	// ==========================================================
	// 100 ms timebase
	logic [31:0] tickCnt_q;
	logic        tick;

	assign tick = tickCnt_q == 32'(TICK_COUNT - 1);

	// free-running tick divider
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tickCnt_q <= 32'h0000_0000;
		end else if (tick) begin
			tickCnt_q <= 32'h0000_0000;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h0000_0001;
		end
	end

	// ==========================================================
	// debounce
	logic       debounced_q;
	logic [8:0] dbCnt_q;
	logic       mismatch;
	logic       latchNew;
	logic [7:0] dbLimit;

	// a setting of zero is treated as one tick
	assign dbLimit  = (dbTime_q == 8'h00) ? 8'h01 : dbTime_q; // RQ4
	assign mismatch = charge_detect_enable && rawDet_q != debounced_q; // RQ1
	// latch once a whole extra tick passes beyond the limit
	assign latchNew = mismatch && tick
		&& dbCnt_q == {1'b0, dbLimit}; // RQ3

	// count ticks while raw differs; any bounce restarts the count
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dbCnt_q <= 9'h000;
		end else if (!mismatch || latchNew) begin
			dbCnt_q <= 9'h000;
		end else if (tick) begin
			dbCnt_q <= dbCnt_q + 9'h001; // RQ4
		end
	end

	// debounced value follows raw after a stable interval
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			debounced_q <= 1'b0;
		end else if (latchNew) begin
			debounced_q <= rawDet_q; // RQ3
		end
	end

	// change alarm: set wins over a same-cycle write-one clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			changeAlarm_q <= 1'b0;
		end else if (latchNew) begin
			changeAlarm_q <= 1'b1; // RQ5
		end else if (wrAlmSta && regReq.wdata[ALM_CHANGE]) begin
			changeAlarm_q <= 1'b0; // RQ7
		end
	end

	// alert pin driven by the masked alarm
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= changeAlarm_q && almEnable_q; // RQ6
		end
	end

	// oscillator request: wake on mismatch, drop in deep sleep after latch
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			oscRequest_q <= 1'b0;
		end else if (mismatch && !latchNew) begin
			oscRequest_q <= 1'b1; // RQ8
		end else if (latchNew && lowestPowerState && oscOffSleep) begin
			oscRequest_q <= 1'b0; // RQ9
		end else if (!lowestPowerState) begin
			oscRequest_q <= mismatch;
		end
	end

	// ==========================================================
	// charge overtemperature protection
	otc_state_e  otcState_q;
	logic [7:0]  alertCnt_q;
	logic [15:0] thrCounts;
	logic [15:0] recCounts;
	logic        measTake;
	logic        below;
	logic        recovered;

	assign thrCounts = 16'(otcThr_q * THR_STEP); // RQ11
	assign recCounts = 16'(otcRec_q * THR_STEP); // RQ11
	// sleep mode only sees results taken inside a burst
	assign measTake  = thermMeas.valid && (!sleepMode || sleepBurst); // RQ14
	assign below     = thermMeas.result < thrCounts; // RQ10
	assign recovered = (otcRec_q != 8'h00 && measTake
		&& thermMeas.result >= recCounts) // RQ18
		|| (otcRec_q == 8'h00 && tempRecReq); // RQ19

	// normal, alert and trip sequencing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			otcState_q <= OTC_NORMAL;
			alertCnt_q <= 8'h00;
		end else if (!otcEn) begin
			otcState_q <= OTC_NORMAL; // RQ12
			alertCnt_q <= 8'h00;
		end else begin
			unique case (otcState_q)
				OTC_NORMAL: begin
					if (measTake && below) begin
						alertCnt_q <= 8'h00;
						if (otcDly_q == 8'h00) begin
							otcState_q <= OTC_TRIP; // RQ13
						end else begin
							otcState_q <= OTC_ALERT; // RQ10
						end
					end
				end
				OTC_ALERT: begin
					if (measTake && !below) begin
						otcState_q <= OTC_NORMAL; // RQ10
					end else if (measTake) begin
						if (alertCnt_q + 8'h01 == otcDly_q) begin
							otcState_q <= OTC_TRIP; // RQ13
						end else begin
							alertCnt_q <= alertCnt_q + 8'h01;
						end
					end
				end
				OTC_TRIP: begin
					if (recovered) begin
						otcState_q <= OTC_NORMAL; // RQ18
					end
				end
			endcase
		end
	end

	logic otcAlert;
	logic otcFault;

	assign otcAlert = otcState_q == OTC_ALERT; // RQ16
	assign otcFault = otcState_q == OTC_TRIP; // RQ16

	// fet, mode and bias outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chargeFetOff_q  <= 1'b0;
			normalModeReq_q <= 1'b0;
			thermBias_q     <= 1'b0;
		end else begin
			chargeFetOff_q  <= otcFault && otcFetCtrl; // RQ17
			normalModeReq_q <= otcAlert; // RQ15
			thermBias_q     <= thermMeasuring || biasOn_q; // RQ20
		end
	end

	// ==========================================================
	// read data, valid in the cycle after the read strobe
	logic [DATA_W-1:0] rdMux;

	always_comb begin
		rdMux = '0;
		unique case (regReq.addr)
			ADDR_CONFIG: rdMux = {12'h000, config_q};
			ADDR_DBTIME: rdMux = {8'h00, dbTime_q};
			ADDR_OTCTHR: rdMux = {8'h00, otcThr_q};
			ADDR_OTCREC: rdMux = {8'h00, otcRec_q};
			ADDR_OTCDLY: rdMux = {8'h00, otcDly_q};
			ADDR_ALMSTA: rdMux = {15'h0000, changeAlarm_q};
			ADDR_ALMENA: rdMux = {15'h0000, almEnable_q};
			ADDR_STATUS: rdMux = {11'h000, oscRequest_q, otcFault,
				otcAlert, debounced_q, rawDet_q}; // RQ2
			ADDR_REGOUT: rdMux = {15'h0000, biasOn_q};
			default:     rdMux = '0;
		endcase
	end

	// read data register: zero unless a read was strobed
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regRdata_q <= '0;
		end else if (rdEn) begin
			regRdata_q <= rdMux;
		end else begin
			regRdata_q <= '0;
		end
	end

endmodule

// >>> testbench/chg_otc_assertions.sv
// checker: port-level properties of the protection block
`timescale 1ns/1ps
module chg_otc_checker #(
	parameter int TICK_COUNT = 10
) (
	input wire logic                      clk_sys,
	input wire logic                      rst,
	input wire chg_otc_pkg::reg_req_s     regReq,
	input wire logic [15:0]               regRdata_q,
	input wire logic                      sleepMode,
	input wire logic                      sleepBurst,
	input wire logic                      thermMeasuring,
	input wire chg_otc_pkg::therm_meas_s  thermMeas,
	input wire logic                      alert_q,
	input wire logic                      chargeFetOff_q,
	input wire logic                      normalModeReq_q,
	input wire logic                      thermBias_q
);
	import chg_otc_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// register port
	property p_rdIdle; !$past(regReq.rd) |-> regRdata_q == '0; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("stray read data");
	property p_unmap; regReq.rd && regReq.addr == 8'h08 |=> regRdata_q == '0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read data");
	// alarm output drops only two cycles after a host write
	property p_alertFall; $fell(alert_q) |-> $past(regReq.wr, 2); endproperty
	a_alertFall: assert property (p_alertFall) else $error("alert drop");
	// ==========================================================
	// overtemperature outputs follow a valid measurement; fet release may also follow a host write
	property p_fetRise; $rose(chargeFetOff_q) |-> $past(thermMeas.valid, 2);
	endproperty
	a_fetRise: assert property (p_fetRise) else $error("fet off cause");
	property p_fetFall;
		$fell(chargeFetOff_q) |-> $past(thermMeas.valid, 2) || $past(regReq.wr, 2);
	endproperty
	a_fetFall: assert property (p_fetFall) else $error("fet on cause");
	property p_normRise; $rose(normalModeReq_q) |-> $past(thermMeas.valid, 2);
	endproperty
	a_normRise: assert property (p_normRise) else $error("normal req");
	property p_sleepGate;
		$rose(normalModeReq_q) |-> $past(!sleepMode || sleepBurst, 2);
	endproperty
	a_sleepGate: assert property (p_sleepGate) else $error("sleep gate");
	// ==========================================================
	// thermistor bias
	property p_biasOn; thermMeasuring |=> thermBias_q; endproperty
	a_biasOn: assert property (p_biasOn) else $error("bias missing");
	property p_biasOff; $fell(thermBias_q) |-> !$past(thermMeasuring); endproperty
	a_biasOff: assert property (p_biasOff) else $error("bias dropped");
	c_alert: cover property ($rose(alert_q));
	c_fet: cover property ($rose(chargeFetOff_q));
	c_norm: cover property ($rose(normalModeReq_q));
endmodule

bind chg_otc_protect chg_otc_checker #(.TICK_COUNT(TICK_COUNT)) i_chk (
	.clk_sys, .rst, .regReq, .regRdata_q, .sleepMode, .sleepBurst,
	.thermMeasuring, .thermMeas, .alert_q, .chargeFetOff_q,
	.normalModeReq_q, .thermBias_q);

// >>> testbench/chg_otc_host.sv
// host model: register master and host-side commands
`timescale 1ns/1ps
module chg_otc_host (
	input  wire logic             clk_sys,
	output chg_otc_pkg::reg_req_s regReq,
	input  wire logic [15:0]      regRdata_q
);
	import chg_otc_pkg::*;
	initial regReq = '0;
	// ==========================================================
	// one-cycle strobes; released lines show inverted values
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		regReq <= '{~a, ~d, 1'b0, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		regReq <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_sys);
		regReq <= '{~a, 16'hFFFF, 1'b0, 1'b0};
		@(posedge clk_sys);
		d = regRdata_q; // data stands in the cycle after the strobe
	endtask
	// ==========================================================
	// host commands
	task automatic clrAlarm();
		wr(ADDR_ALMSTA, 16'h0001);
	endtask
	task automatic recover();
		wr(ADDR_RECCMD, 16'h0001);
	endtask
	task automatic bias(input logic v);
		wr(ADDR_REGOUT, {15'h0000, v});
	endtask
endmodule

// >>> testbench/test_charge_detect_and_otc_protection.sv
// testbench: detector debounce and overtemperature scenarios
`timescale 1ns/1ps
module test_charge_detect_and_otc_protection;
	import chg_otc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	reg_req_s    regReq;
	logic [15:0] regRdata_q;
	logic        pin = 1'b0;
	logic        lowestPowerState = 1'b0;
	logic        sleepMode = 1'b0;
	logic        sleepBurst = 1'b0;
	logic        thermMeasuring = 1'b0;
	therm_meas_s thermMeas = '0;
	logic        alert_q, chargeFetOff_q, oscRequest_q;
	logic        normalModeReq_q, thermBias_q;
	int          failures = 0;
	int          nCompared = 0;
	longint      t0;
	// clock at 250 MHz
	always #2 clk_sys = ~clk_sys;
	chg_otc_protect #(.TICK_COUNT(4)) i_chg_otc_protect (.clk_sys, .rst,
		.regReq, .regRdata_q, .chgDetectPin(pin), .lowestPowerState,
		.sleepMode, .sleepBurst, .thermMeasuring, .thermMeas, .alert_q,
		.chargeFetOff_q, .oscRequest_q, .normalModeReq_q, .thermBias_q);
	chg_otc_host host (.clk_sys, .regReq, .regRdata_q);
	// ==========================================================
	// compare and report
	task check(string n, logic [15:0] s, logic [15:0] e);
		nCompared++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task conclude();
		$display("compared %0d failures %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task rdChk(logic [7:0] a, logic [15:0] m, logic [15:0] e);
		logic [15:0] d;
		host.rd(a, d);
		check($sformatf("reg %h", a), d & m, e);
	endtask
	// poll the debounced flag under a bound
	task waitDeb(logic v);
		logic [15:0] d;
		int n;
		n = 0;
		do begin
			host.rd(ADDR_STATUS, d);
			n++;
			if (n > 80) begin
				failures++;
				conclude();
			end
		end while (d[STA_DEBOUNCED] !== v);
	endtask
	// one thermistor result, then the alert and fault status bits
	task meas(logic [15:0] r, logic [15:0] e);
		@(posedge clk_sys);
		thermMeasuring <= 1'b1;
		thermMeas <= '{1'b1, r};
		@(posedge clk_sys);
		thermMeasuring <= 1'b0;
		thermMeas <= '{1'b0, ~r};
		rdChk(ADDR_STATUS, 16'h000C, e);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rdChk(ADDR_CONFIG, 16'h000F, {12'h000, CONFIG_RST});
		rdChk(ADDR_DBTIME, 16'h00FF, {8'h00, DBTIME_RST});
		rdChk(ADDR_OTCDLY, 16'h00FF, {8'h00, OTCDLY_RST});
		rdChk(8'h08, 16'hFFFF, 16'h0000);
		host.wr(ADDR_STATUS, 16'hFFFF);
		rdChk(ADDR_STATUS, 16'h001F, 16'h0000);
		host.wr(ADDR_DBTIME, 16'h0002);
		host.wr(ADDR_ALMENA, 16'h0001);
		pin <= 1'b1;
		repeat (40) @(posedge clk_sys);
		rdChk(ADDR_STATUS, 16'h0002, 16'h0000);
		check("osc", oscRequest_q, 0);
		host.wr(ADDR_CONFIG, 16'h0001);
		t0 = $time;
		repeat (3) @(posedge clk_sys);
		rdChk(ADDR_STATUS, 16'h0003, 16'h0001);
		check("osc", oscRequest_q, 1);
		waitDeb(1'b1);
		check("interval", ($time - t0) / 4 inside {[9:24]}, 1);
		repeat (3) @(posedge clk_sys);
		check("alert", alert_q, 1);
		check("osc", oscRequest_q, 0);
		host.clrAlarm();
		repeat (2) @(posedge clk_sys);
		check("alert", alert_q, 0);
		rdChk(ADDR_ALMSTA, 16'h0001, 16'h0000);
		host.wr(ADDR_ALMENA, 16'h0000);
		lowestPowerState <= 1'b1;
		pin <= 1'b0;
		waitDeb(1'b0);
		repeat (3) @(posedge clk_sys);
		check("alert", alert_q, 0);
		rdChk(ADDR_ALMSTA, 16'h0001, 16'h0001);
		check("osc", oscRequest_q, 1);
		host.wr(ADDR_CONFIG, 16'h0009);
		pin <= 1'b1;
		waitDeb(1'b1);
		repeat (2) @(posedge clk_sys);
		check("osc", oscRequest_q, 0);
		lowestPowerState <= 1'b0;
		host.wr(ADDR_OTCTHR, 16'h00FF);
		host.wr(ADDR_OTCREC, 16'h00FF);
		host.wr(ADDR_OTCDLY, 16'h0003);
		host.wr(ADDR_CONFIG, 16'h0006);
		meas(16'd13769, 16'h0004);
		check("normal", normalModeReq_q, 1);
		meas(16'd13770, 16'h0000);
		check("normal", normalModeReq_q, 0);
		meas(16'h0000, 16'h0004);
		meas(16'h0000, 16'h0004);
		meas(16'h0000, 16'h0004);
		check("fet", chargeFetOff_q, 0);
		meas(16'h0000, 16'h0008);
		check("fet", chargeFetOff_q, 1);
		meas(16'd13769, 16'h0008);
		meas(16'd13770, 16'h0000);
		check("fet", chargeFetOff_q, 0);
		sleepMode <= 1'b1;
		meas(16'h0000, 16'h0000);
		sleepBurst <= 1'b1;
		meas(16'h0000, 16'h0004);
		sleepMode <= 1'b0;
		sleepBurst <= 1'b0;
		meas(16'd13770, 16'h0000);
		host.wr(ADDR_CONFIG, 16'h0004);
		meas(16'h0000, 16'h0000);
		host.wr(ADDR_OTCREC, 16'h0000);
		host.wr(ADDR_OTCDLY, 16'h0000);
		host.wr(ADDR_CONFIG, 16'h0006);
		meas(16'h0000, 16'h0008);
		meas(16'hFFFF, 16'h0008);
		host.recover();
		rdChk(ADDR_STATUS, 16'h000C, 16'h0000);
		check("fet", chargeFetOff_q, 0);
		host.bias(1'b1);
		repeat (2) @(posedge clk_sys);
		check("bias", thermBias_q, 1);
		host.bias(1'b0);
		repeat (2) @(posedge clk_sys);
		check("bias", thermBias_q, 0);
		conclude();
	end
endmodule
